// ### mdbi_pkg.sv
package mdbi_pkg;

   // Channel layout of the full board.
   localparam int NUM_CHANNELS = 16;
   localparam int NUM_PAIRS = 8;
   localparam int CODE_W = 12;
   localparam int LOW_W = 8;
   localparam int HIGH_W = 4;

   // Expansion-bus I/O address layout.
   localparam int IO_ADDR_W = 10;
   localparam int BASE_LSB = 5;
   localparam int BASE_W = 5;
   localparam int SLOT_W = 5;

   // Factory jumper and switch settings.
   localparam logic [IO_ADDR_W-1:0] IO_BASE_DEFAULT = 10'h300;
   localparam logic [BASE_W-1:0] BASE_SWITCH_DEFAULT =
      IO_BASE_DEFAULT[IO_ADDR_W-1:BASE_LSB];
   localparam logic WAIT_JUMPER_DEFAULT = 1'h0;
   localparam logic [NUM_PAIRS-1:0] XFER_JUMPER_DEFAULT = 8'h00;

   // Register bus layout: one aligned word for each byte register.
   localparam int AXI_ADDR_W = 12;
   localparam int AXI_DATA_W = 32;
   localparam int WORD_LSB = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // Write path states.
   typedef enum logic [1:0] {
      WR_IDLE = 2'b00,
      WR_WAIT = 2'b01,
      WR_RESP = 2'b10
   } mdbi_wr_state_t;

   // Read path states.
   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_WAIT = 2'b01,
      RD_RESP = 2'b10
   } mdbi_rd_state_t;

endpackage

// ### mdbi_sync.sv
`timescale 1ns/1ps
module mdbi_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset_n,
   // Asynchronous level in, synchronised level out.
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);

   logic [WIDTH-1:0] meta;

   // Two flip-flops; only the second stage reads the first.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         meta <= RESET_VALUE;
         level_out <= RESET_VALUE;
      end else begin
         meta <= pin_in;
         level_out <= meta;
      end
   end

endmodule

// ### mdbi_chan.sv
`timescale 1ns/1ps
module mdbi_chan (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset_n,
   // Byte writes from the bus.
   input wire logic low_we,
   input wire logic high_we,
   input wire logic [mdbi_pkg::LOW_W-1:0] byte_in,
   // Update control.
   input wire logic simul_mode,
   input wire logic xfer,
   // Readback and analog side.
   output logic [mdbi_pkg::LOW_W-1:0] low_byte,
   output logic [mdbi_pkg::HIGH_W-1:0] high_nib,
   output logic [mdbi_pkg::CODE_W-1:0] dac_code,
   output logic dac_update
);

   logic [mdbi_pkg::CODE_W-1:0] hold_code;
   wire logic [mdbi_pkg::CODE_W-1:0] next_hold_code;
   wire logic load_now;

   // The high byte joins the stored low byte into one code.
   assign next_hold_code = high_we ?
      {byte_in[mdbi_pkg::HIGH_W-1:0], low_byte} : hold_code; // R1 R11

   // Individual pairs load on the high byte, grouped pairs on a transfer.
   assign load_now = (high_we & ~simul_mode) | (xfer & simul_mode); // R2 R4 R5

   // First rank holds the bytes, second rank drives the converter.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         low_byte <= '0;
         high_nib <= '0;
         hold_code <= '0;
         dac_code <= '0; // R10
         dac_update <= 1'b0;
      end else begin
         if (low_we) begin
            low_byte <= byte_in; // R2
         end
         if (high_we) begin
            high_nib <= byte_in[mdbi_pkg::HIGH_W-1:0];
            hold_code <= next_hold_code;
         end
         if (load_now) begin
            dac_code <= next_hold_code;
         end
         dac_update <= load_now;
      end
   end

endmodule

// ### mdbi_top.sv
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// R1: Host writes each code as two bytes; the device joins them into one word.
// R2: Individual mode keeps the output until the high byte is written.
// R3: Each DAC pair chooses simultaneous update on its own jumper.
// R4: Simultaneous pairs only load the holding latch, output stays unchanged.
// R5: A read of any decoded board address transfers all grouped pairs at once.
// R6: I/O address bits 9 to 5 must match the base switch setting.
// R7: Base defaults to 300 hex, update mode defaults to individual.
// R8: Fitted wait jumper adds one wait state to board accesses.
// R9: The wait state applies only to accesses that hit this board.
// R10: No defined output code is promised after power-up.
// R11: Each channel has a low byte register and a high four-bit register.
// R12: Sixteen channels decode 32 registers, eight channels decode 16.
// R13: Channel n low byte at base plus 2n, high byte at plus one.
module mdbi_top #(
   parameter int BOARD_CHANNELS = 16
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset_n,

   // AXI4-Lite write address channel.
   input wire logic [mdbi_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,

   // AXI4-Lite write data channel.
   input wire logic [mdbi_pkg::AXI_DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,

   // AXI4-Lite write response channel.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,

   // AXI4-Lite read address channel.
   input wire logic [mdbi_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,

   // AXI4-Lite read data channel.
   output logic [mdbi_pkg::AXI_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,

   // Board switches and jumpers, asynchronous levels.
   input wire logic [mdbi_pkg::BASE_W-1:0] base_switch,
   input wire logic wait_jumper,
   input wire logic [mdbi_pkg::NUM_PAIRS-1:0] xfer_jumper,

   // Converter side.
   output logic [mdbi_pkg::NUM_CHANNELS*mdbi_pkg::CODE_W-1:0] dac_code,
   output logic [mdbi_pkg::NUM_CHANNELS-1:0] dac_update
);

   // Number of byte registers this board variant answers to.
   // The small variant answers to half the slots; the rest return a decode error.
   localparam logic [mdbi_pkg::SLOT_W:0] SLOT_COUNT =
      (mdbi_pkg::SLOT_W+1)'(2 * BOARD_CHANNELS); // R12

   // Synchronised switch and jumper levels.
   logic [mdbi_pkg::BASE_W-1:0] base_sel;
   logic wait_sel;
   logic [mdbi_pkg::NUM_PAIRS-1:0] xfer_sel;

   // Write path storage.
   mdbi_pkg::mdbi_wr_state_t wr_state;
   mdbi_pkg::mdbi_wr_state_t next_wr_state;
   logic [mdbi_pkg::AXI_ADDR_W-1:0] aw_addr;
   logic [mdbi_pkg::LOW_W-1:0] w_byte;
   logic w_lane0;

   // Read path storage.
   mdbi_pkg::mdbi_rd_state_t rd_state;
   mdbi_pkg::mdbi_rd_state_t next_rd_state;
   logic [mdbi_pkg::AXI_ADDR_W-1:0] ar_addr;

   // Per-channel readback.
   // Storage stays in the channels; these arrays only route it back to the bus.
   logic [mdbi_pkg::LOW_W-1:0] chan_low [mdbi_pkg::NUM_CHANNELS];
   logic [mdbi_pkg::HIGH_W-1:0] chan_high [mdbi_pkg::NUM_CHANNELS];

   // Switch settings come from pins and pass two flip-flops first.
   mdbi_sync #(
      .WIDTH(mdbi_pkg::BASE_W),
      .RESET_VALUE(mdbi_pkg::BASE_SWITCH_DEFAULT)
   ) u_base_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .pin_in(base_switch),
      .level_out(base_sel)
   ); // R7

   // The wait jumper is a pin as well and is synchronised the same way.
   mdbi_sync #(
      .WIDTH(1),
      .RESET_VALUE(mdbi_pkg::WAIT_JUMPER_DEFAULT)
   ) u_wait_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .pin_in(wait_jumper),
      .level_out(wait_sel)
   );

   // Transfer jumpers, one for each pair of channels.
   mdbi_sync #(
      .WIDTH(mdbi_pkg::NUM_PAIRS),
      .RESET_VALUE(mdbi_pkg::XFER_JUMPER_DEFAULT)
   ) u_xfer_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .pin_in(xfer_jumper),
      .level_out(xfer_sel)
   ); // R3 R7

   // Bus words map to I/O addresses, one word per byte register.
   wire logic [mdbi_pkg::IO_ADDR_W-1:0] wr_io_addr;
   wire logic [mdbi_pkg::IO_ADDR_W-1:0] rd_io_addr;
   wire logic [mdbi_pkg::SLOT_W-1:0] wr_slot;
   wire logic [mdbi_pkg::SLOT_W-1:0] rd_slot;
   assign wr_io_addr = aw_addr[mdbi_pkg::WORD_LSB +: mdbi_pkg::IO_ADDR_W];
   assign rd_io_addr = ar_addr[mdbi_pkg::WORD_LSB +: mdbi_pkg::IO_ADDR_W];
   assign wr_slot = wr_io_addr[mdbi_pkg::SLOT_W-1:0];
   assign rd_slot = rd_io_addr[mdbi_pkg::SLOT_W-1:0];

   // Board decode: base match on the upper bits, slot within the variant.
   wire logic wr_base_hit;
   wire logic rd_base_hit;
   wire logic wr_hit;
   wire logic rd_hit;
   assign wr_base_hit =
      wr_io_addr[mdbi_pkg::IO_ADDR_W-1:mdbi_pkg::BASE_LSB] == base_sel; // R6
   assign rd_base_hit =
      rd_io_addr[mdbi_pkg::IO_ADDR_W-1:mdbi_pkg::BASE_LSB] == base_sel; // R6
   assign wr_hit = wr_base_hit & ({1'b0, wr_slot} < SLOT_COUNT); // R12
   assign rd_hit = rd_base_hit & ({1'b0, rd_slot} < SLOT_COUNT); // R12

   // Address and data are both held; a wait is owed only on board hits.
   // Holding the answer back one cycle gives slow on-board parts time to settle.
   wire logic wr_both_held;
   wire logic wr_need_wait;
   wire logic wr_fire;
   assign wr_both_held = ~s_axi_awready & ~s_axi_wready;
   assign wr_need_wait = wait_sel & wr_hit; // R8 R9
   assign wr_fire = ((wr_state == mdbi_pkg::WR_IDLE) & wr_both_held & ~wr_need_wait)
      | (wr_state == mdbi_pkg::WR_WAIT);

   // Read fires at once or after the single wait state.
   wire logic rd_held;
   wire logic rd_need_wait;
   wire logic rd_fire;
   wire logic xfer_pulse;
   assign rd_held = ~s_axi_arready;
   assign rd_need_wait = wait_sel & rd_hit; // R8 R9
   assign rd_fire = ((rd_state == mdbi_pkg::RD_IDLE) & rd_held & ~rd_need_wait)
      | (rd_state == mdbi_pkg::RD_WAIT);
   assign xfer_pulse = rd_fire & rd_hit; // R5

   // Write path sequencing.
   always_comb begin
      case (wr_state)
         mdbi_pkg::WR_IDLE: begin
            if (wr_both_held & wr_need_wait) begin
               next_wr_state = mdbi_pkg::WR_WAIT; // R8
            end else if (wr_both_held) begin
               next_wr_state = mdbi_pkg::WR_RESP;
            end else begin
               next_wr_state = mdbi_pkg::WR_IDLE;
            end
         end
         mdbi_pkg::WR_WAIT: begin
            next_wr_state = mdbi_pkg::WR_RESP;
         end
         mdbi_pkg::WR_RESP: begin
            next_wr_state = s_axi_bready ? mdbi_pkg::WR_IDLE : mdbi_pkg::WR_RESP;
         end
         default: begin
            next_wr_state = mdbi_pkg::WR_IDLE;
         end
      endcase
   end

   // Read path sequencing.
   // A missed read never waits and never moves a grouped code.
   always_comb begin
      case (rd_state)
         mdbi_pkg::RD_IDLE: begin
            if (rd_held & rd_need_wait) begin
               next_rd_state = mdbi_pkg::RD_WAIT; // R8
            end else if (rd_held) begin
               next_rd_state = mdbi_pkg::RD_RESP;
            end else begin
               next_rd_state = mdbi_pkg::RD_IDLE;
            end
         end
         mdbi_pkg::RD_WAIT: begin
            next_rd_state = mdbi_pkg::RD_RESP;
         end
         mdbi_pkg::RD_RESP: begin
            next_rd_state = s_axi_rready ? mdbi_pkg::RD_IDLE : mdbi_pkg::RD_RESP;
         end
         default: begin
            next_rd_state = mdbi_pkg::RD_IDLE;
         end
      endcase
   end

   // Write address and data are taken in either order and held.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_addr <= '0;
         w_byte <= '0;
         w_lane0 <= 1'b0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr <= s_axi_awaddr;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_byte <= s_axi_wdata[mdbi_pkg::LOW_W-1:0];
            w_lane0 <= s_axi_wstrb[0];
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Both sequencers step on every edge; their answers are registered below.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         wr_state <= mdbi_pkg::WR_IDLE;
         rd_state <= mdbi_pkg::RD_IDLE;
      end else begin
         wr_state <= next_wr_state;
         rd_state <= next_rd_state;
      end
   end

   // Write response: misses on the base or slot answer with a decode error.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= mdbi_pkg::RESP_OKAY;
      end else begin
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? mdbi_pkg::RESP_OKAY : mdbi_pkg::RESP_DECERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read address is held until the data has been taken.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b1;
         ar_addr <= '0;
      end else begin
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            ar_addr <= s_axi_araddr;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Readback selects the low byte or the high nibble of one channel.
   // Unused data bits read as zero, so software needs no mask.
   wire logic [mdbi_pkg::SLOT_W-2:0] rd_chan;
   wire logic [mdbi_pkg::LOW_W-1:0] rd_byte;
   wire logic [mdbi_pkg::AXI_DATA_W-1:0] rd_word;
   assign rd_chan = rd_slot[mdbi_pkg::SLOT_W-1:1];
   assign rd_byte = rd_slot[0] ?
      {{(mdbi_pkg::LOW_W-mdbi_pkg::HIGH_W){1'b0}}, chan_high[rd_chan]} :
      chan_low[rd_chan]; // R11 R13
   assign rd_word = rd_hit ?
      {{(mdbi_pkg::AXI_DATA_W-mdbi_pkg::LOW_W){1'b0}}, rd_byte} : '0;

   // Read response; a board hit also triggers the grouped transfer.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= mdbi_pkg::RESP_OKAY;
      end else begin
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? mdbi_pkg::RESP_OKAY : mdbi_pkg::RESP_DECERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // A write reaches a channel only on a hit with byte lane 0 enabled.
   wire logic wr_byte_go;
   assign wr_byte_go = wr_fire & wr_hit & w_lane0; // R1

   // One channel per slot pair; each pair shares its transfer jumper.
   // A transfer that meets a high-byte write in the same cycle moves the new code,
   // because each channel forwards the word it is loading.
   genvar ch;
   generate
      for (ch = 0; ch < mdbi_pkg::NUM_CHANNELS; ch++) begin : g_chan
         wire logic sel;
         wire logic low_we;
         wire logic high_we;
         assign sel = wr_slot[mdbi_pkg::SLOT_W-1:1] == (mdbi_pkg::SLOT_W-1)'(ch);
         assign low_we = wr_byte_go & sel & ~wr_slot[0]; // R13
         assign high_we = wr_byte_go & sel & wr_slot[0]; // R13
         mdbi_chan u_chan (
            .sys_clk(sys_clk),
            .reset_n(reset_n),
            .low_we(low_we),
            .high_we(high_we),
            .byte_in(w_byte),
            .simul_mode(xfer_sel[ch/2]), // R3
            .xfer(xfer_pulse),
            .low_byte(chan_low[ch]),
            .high_nib(chan_high[ch]),
            .dac_code(dac_code[ch*mdbi_pkg::CODE_W +: mdbi_pkg::CODE_W]),
            .dac_update(dac_update[ch])
         );
      end
   endgenerate

endmodule

// ### mdbi_properties.sv
`timescale 1ns/1ps
module mdbi_checker (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset_n,
   // Register bus handshakes and answers.
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   // Jumpers and converter side.
   input wire logic [7:0] xfer_jumper,
   input wire logic [191:0] dac_code,
   input wire logic [15:0] dac_update
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   logic [15:0] grouped;
   // Each jumper bit covers both channels of its pair.
   always_comb begin
      for (int p = 0; p < 8; p++) begin
         grouped[2*p] = xfer_jumper[p];
         grouped[2*p+1] = xfer_jumper[p];
      end
   end
   // Bus timing and the cause of every output update.
   wr_resp_time_a: assert property (!s_axi_awready && !s_axi_wready && !s_axi_bvalid
      |-> ##[1:2] s_axi_bvalid) else $error("write response late");
   rd_resp_time_a: assert property (s_axi_arvalid && s_axi_arready
      |=> ##[1:2] s_axi_rvalid) else $error("read response late");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   ready_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   upd_cause_a: assert property (|dac_update |-> s_axi_bvalid || s_axi_rvalid)
      else $error("update without access");
   code_with_pulse_a: assert property ($changed(dac_code) |-> |dac_update)
      else $error("code changed silently");
   grouped_hold_a: assert property ($rose(s_axi_bvalid) && !$rose(s_axi_rvalid)
      |-> (dac_update & grouped) == 16'h0) else $error("grouped channel updated on write");
   indiv_read_a: assert property ($rose(s_axi_rvalid) && !$rose(s_axi_bvalid)
      |-> (dac_update & ~grouped) == 16'h0) else $error("single channel updated on read");
   rdata_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data too wide");
   miss_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h3
      |-> s_axi_rdata == 32'h0) else $error("data on missed read");
   pulse_once_a: assert property (|dac_update |=> (dac_update & $past(dac_update)) == 16'h0)
      else $error("update pulse too long");
endmodule

// ### mdbi_host.sv
`timescale 1ns/1ps
module mdbi_host (
   // Clock.
   input wire logic sys_clk,
   // Write channels.
   output logic [11:0] s_axi_awaddr,
   output logic [2:0] s_axi_awprot,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // Read channels.
   output logic [11:0] s_axi_araddr,
   output logic [2:0] s_axi_arprot,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // The bus starts idle.
   initial begin
      {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'h1;
   end
   // One byte write at an I/O address; bready may come late; released lines are scrambled.
   task automatic wr(input logic [9:0] a, input logic [7:0] d, input int slow,
                     output logic [1:0] r, output int n);
      logic done;
      n = 0;
      s_axi_awaddr <= {a, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         done = (s_axi_bvalid === 1'b1) && (s_axi_bready === 1'b1);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~s_axi_wdata;
         end
         s_axi_bready <= !done && (n >= slow);
      end while (!done);
      r = s_axi_bresp;
   endtask
   // One byte read at an I/O address.
   task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r,
                     output int n);
      logic done;
      n = 0;
      s_axi_araddr <= {a, 2'h0};
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         done = (s_axi_rvalid === 1'b1) && (s_axi_rready === 1'b1);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~s_axi_araddr;
         end
         s_axi_rready <= !done;
      end while (!done);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
endmodule

// ### multichannel_dac_bus_interface_bench.sv
`timescale 1ns/1ps
module multichannel_dac_bus_interface_bench;
   // Clock, reset, settings and bus wires.
   logic sys_clk, reset_n, wait_jumper;
   logic [4:0] base_switch;
   logic [7:0] xfer_jumper;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [191:0] dac_code;
   logic [15:0] dac_update;
   int failures = 0;
   int n_compared = 0;

   mdbi_top DUT (.*);
   mdbi_host host (.*);

   // The clock runs at 100 MHz.
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [11:0] code(input int n);
      return dac_code[12*n +: 12];
   endfunction
   task automatic settle();
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic put(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
      logic [1:0] r;
      int n;
      host.wr(a, d, 0, r, n);
      chk("bresp", er, r);
   endtask
   task automatic get(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      int n;
      host.rd(a, d, r, n);
      chk("rdata", ed, d);
      chk("rresp", er, r);
   endtask

   // A single channel joins its two bytes and reads them back.
   task automatic t_indiv();
      put(10'h30a, 8'ha5, 2'h0);
      chk("ch5 after low", 32'h0, code(5));
      put(10'h30b, 8'hfc, 2'h0);
      chk("ch5 after high", 32'hca5, code(5));
      get(10'h30a, 32'ha5, 2'h0);
      get(10'h30b, 32'hc, 2'h0);
   endtask
   // A grouped pair holds its codes until any board read.
   task automatic t_simul();
      xfer_jumper <= 8'h02;
      settle();
      put(10'h304, 8'h34, 2'h0);
      put(10'h305, 8'h12, 2'h0);
      put(10'h307, 8'h07, 2'h0);
      chk("ch2 held", 32'h0, code(2));
      chk("ch3 held", 32'h0, code(3));
      put(10'h309, 8'h09, 2'h0);
      chk("ch4 direct", 32'h900, code(4));
      get(10'h31f, 32'h0, 2'h0);
      chk("ch2 moved", 32'h234, code(2));
      chk("ch3 moved", 32'h700, code(3));
   endtask
   // The top base decodes; the old base misses and moves nothing.
   task automatic t_decode();
      base_switch <= 5'h1f;
      settle();
      put(10'h3e0, 8'h11, 2'h0);
      put(10'h3e1, 8'h02, 2'h0);
      chk("ch0 at top base", 32'h211, code(0));
      put(10'h3e5, 8'h03, 2'h0);
      put(10'h30b, 8'h07, 2'h3);
      get(10'h304, 32'h0, 2'h3);
      chk("ch5 kept", 32'hca5, code(5));
      chk("ch2 kept", 32'h234, code(2));
      base_switch <= 5'h18;
      settle();
   endtask
   // The wait state lengthens board hits only.
   task automatic t_wait();
      logic [31:0] d;
      logic [1:0] r;
      int n;
      host.wr(10'h300, 8'h01, 0, r, n);
      chk("plain write cycles", 32'd3, n);
      wait_jumper <= 1'b1;
      settle();
      host.wr(10'h300, 8'h02, 0, r, n);
      chk("waited write cycles", 32'd4, n);
      host.wr(10'h200, 8'h02, 0, r, n);
      chk("missed write cycles", 32'd3, n);
      host.rd(10'h301, d, r, n);
      chk("waited read cycles", 32'd4, n);
      host.wr(10'h301, 8'h05, 6, r, n);
      chk("slow answer", 32'h0, r);
      chk("ch0 code", 32'h502, code(0));
   endtask

   task automatic close_out();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Main sequence after a four-cycle reset.
   initial begin
      reset_n = 1'b0;
      base_switch = 5'h18;
      wait_jumper = 1'b0;
      xfer_jumper = 8'h00;
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      settle();
      chk("codes after reset", 32'h0, 32'(|dac_code));
      t_indiv();
      t_simul();
      t_decode();
      t_wait();
      close_out();
   end
   // A hang ends the run as a mismatch.
   initial begin
      repeat (5000) @(posedge sys_clk);
      failures++;
      close_out();
   end
endmodule

bind mdbi_top mdbi_checker chk_i (.*);
